// ---- common/chan_ctrl_pkg.sv ----
// Package: register map, field widths and timing constants for channel control
// Assumes a 32-bit AHB-Lite slave on clk_sys and a link clock domain for the pins
package chan_ctrl_pkg;
   localparam int unsigned NUM_CHAN = 8;
   localparam int unsigned RESULT_BITS = 12;
   // Byte addresses of the registers
   localparam logic [7:0] ADDR_PIN_CFG = 8'h00;
   localparam logic [7:0] ADDR_DIR_CFG = 8'h04;
   localparam logic [7:0] ADDR_DRIVE_CFG = 8'h08;
   localparam logic [7:0] ADDR_OUT_LEVELS = 8'h0c;
   localparam logic [7:0] ADDR_IN_LEVELS = 8'h10;
   localparam logic [7:0] ADDR_GEN_CTRL = 8'h14;
   localparam logic [7:0] ADDR_STATUS = 8'h18;
   localparam logic [7:0] ADDR_RESULT = 8'h1c;
   localparam logic [7:0] ADDR_CONV_CTRL = 8'h20;
   // Field positions
   localparam int unsigned BIT_SW_RESET = 0;
   localparam int unsigned BIT_READY = 0;
   localparam int unsigned BIT_BUSY = 1;
   localparam int unsigned BIT_START = 0;
   localparam int unsigned CHSEL_LSB = 4;
   localparam int unsigned CHSEL_W = 3;
   // Reset values: all channels analog
   localparam logic [7:0] RST_CFG = 8'h00;
   // Timing
   localparam int unsigned CLK_PERIOD_NS = 50;
   localparam int unsigned T_RST_MS = 5;
   localparam int unsigned T_PU_MS = 5;
   localparam int unsigned T_ACQ_NS = 400;
   localparam int unsigned T_CONV_NS = 600;
   localparam int unsigned RST_CYCLES = (T_RST_MS * 1000000) / CLK_PERIOD_NS;
   localparam int unsigned PU_CYCLES = (T_PU_MS * 1000000) / CLK_PERIOD_NS;
   localparam int unsigned ACQ_CYCLES = (T_ACQ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned CONV_CYCLES = T_CONV_NS / CLK_PERIOD_NS;
   localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
   localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
endpackage

// ---- logic/chan_ctrl.sv ----
// Channel controller: AHB-Lite registers, pin modes, reset timing, sampling switch
// Assumes one AHB-Lite master, a link clock for pins, and an external SAR comparator
//
// What this block does
// R1: After reset all eight channels are analog inputs.
// R2: Per-channel pin config bit switches a channel from analog to digital.
// R3: Direction bit sets digital input or output for a gpio channel.
// R4: Input levels register returns sampled levels of digital input channels.
// R5: Output levels register sets levels of digital output channels.
// R6: Drive select bit picks open-drain or push-pull per output.
// R7: Software reset completes within 5 ms, then clears its own bit.
// R8: Host waits 5 ms after supply before register access.
// R9: Sampling switch closed during acquisition, open during conversion.
// R10: Result is 12-bit unsigned straight binary.
// R11: Mode decode from pin config, direction and drive bits.
// R12: Input levels also report actual level of output channels.
// R13: Registers are one bit per channel, in channel order.
`timescale 1ns/1ps
module chan_ctrl #(
   parameter int unsigned RST_CYC = chan_ctrl_pkg::RST_CYCLES,
   parameter int unsigned PU_CYC = chan_ctrl_pkg::PU_CYCLES
) (
   // System clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // Link clock domain
   input wire logic clk_link,
   input wire logic rst_link_n,
   // Channel pads
   input wire logic [7:0] pad_in,
   output logic [7:0] pad_out,
   output logic [7:0] pad_oe,
   // Converter analog front end
   input wire logic cmp_out,
   output logic sampling_switch,
   output logic [7:0] chan_select,
   output logic [11:0] dac_code
);
   localparam int unsigned N = chan_ctrl_pkg::NUM_CHAN;
   localparam int unsigned RB = chan_ctrl_pkg::RESULT_BITS;

   //--------------------------------------------------------------
   // Registers
   //--------------------------------------------------------------
   logic [N-1:0] pin_cfg_ff, dir_cfg_ff, drive_ff, out_lvl_ff;
   logic [N-1:0] nxt_pin_cfg, nxt_dir_cfg, nxt_drive, nxt_out_lvl;
   logic sw_rst_ff, nxt_sw_rst;
   logic [22:0] rst_cnt_ff, nxt_rst_cnt;
   logic [22:0] pu_cnt_ff, nxt_pu_cnt;
   logic ready_ff, nxt_ready;
   logic ph_wr_ff, ph_rd_ff, nxt_ph_wr, nxt_ph_rd;
   logic [7:0] ph_addr_ff, nxt_ph_addr;
   logic [31:0] rdata_ff, nxt_rdata;
   logic [N-1:0] lvl_meta_ff, lvl_sync_ff;
   logic [N-1:0] pad_level;
   logic start_req;
   logic [2:0] conv_chan_ff, nxt_conv_chan;
   logic [RB-1:0] result_ff, nxt_result;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_ACQ = 2'b01,
      ST_CONV = 2'b10
   } conv_state_t;
   conv_state_t st_ff, nxt_st;
   logic [4:0] cyc_ff, nxt_cyc;
   logic [3:0] bit_ff, nxt_bit;
   logic [RB-1:0] trial_ff, nxt_trial;
   logic sw_ff, nxt_sw;
   logic [7:0] chan_sel_ff, nxt_chan_sel;

   function automatic logic [31:0] widen(input logic [N-1:0] v);
      widen = {{(32 - N){1'b0}}, v};
   endfunction

   //--------------------------------------------------------------
   // Bus slave
   //--------------------------------------------------------------
   logic take;
   assign take = hsel && hready && (htrans == chan_ctrl_pkg::HTRANS_NONSEQ);

   always_comb begin
      nxt_ph_wr = take && hwrite;
      nxt_ph_rd = take && !hwrite;
      nxt_ph_addr = take ? haddr[7:0] : ph_addr_ff;
      nxt_pin_cfg = pin_cfg_ff;
      nxt_dir_cfg = dir_cfg_ff;
      nxt_drive = drive_ff;
      nxt_out_lvl = out_lvl_ff;
      nxt_sw_rst = sw_rst_ff;
      nxt_rst_cnt = rst_cnt_ff;
      start_req = 1'b0;
      nxt_conv_chan = conv_chan_ff;
      nxt_rdata = rdata_ff;
      if (ph_wr_ff) begin
         case (ph_addr_ff)
            chan_ctrl_pkg::ADDR_PIN_CFG: nxt_pin_cfg = hwdata[N-1:0]; // R2 R13
            chan_ctrl_pkg::ADDR_DIR_CFG: nxt_dir_cfg = hwdata[N-1:0]; // R3
            chan_ctrl_pkg::ADDR_DRIVE_CFG: nxt_drive = hwdata[N-1:0]; // R6
            chan_ctrl_pkg::ADDR_OUT_LEVELS: nxt_out_lvl = hwdata[N-1:0]; // R5
            chan_ctrl_pkg::ADDR_GEN_CTRL: begin
               if (hwdata[chan_ctrl_pkg::BIT_SW_RESET]) begin
                  nxt_sw_rst = 1'b1;
               end
            end
            chan_ctrl_pkg::ADDR_CONV_CTRL: begin
               start_req = hwdata[chan_ctrl_pkg::BIT_START];
               nxt_conv_chan = hwdata[chan_ctrl_pkg::CHSEL_LSB +: chan_ctrl_pkg::CHSEL_W];
            end
            default: ;
         endcase
      end
      // Software reset: count, restore config, self-clear
      if (sw_rst_ff) begin
         nxt_pin_cfg = chan_ctrl_pkg::RST_CFG; // R1
         nxt_dir_cfg = chan_ctrl_pkg::RST_CFG;
         nxt_drive = chan_ctrl_pkg::RST_CFG;
         nxt_out_lvl = chan_ctrl_pkg::RST_CFG;
         if (rst_cnt_ff >= 23'(RST_CYC - 1)) begin
            // A new request in the last cycle wins over the self-clear
            if (!(ph_wr_ff && ph_addr_ff == chan_ctrl_pkg::ADDR_GEN_CTRL &&
                  hwdata[chan_ctrl_pkg::BIT_SW_RESET])) begin
               nxt_sw_rst = 1'b0; // R7
            end
            nxt_rst_cnt = '0;
         end else begin
            nxt_rst_cnt = rst_cnt_ff + 23'd1;
         end
      end
      if (nxt_ph_rd) begin
         case (haddr[7:0])
            chan_ctrl_pkg::ADDR_PIN_CFG: nxt_rdata = widen(pin_cfg_ff);
            chan_ctrl_pkg::ADDR_DIR_CFG: nxt_rdata = widen(dir_cfg_ff);
            chan_ctrl_pkg::ADDR_DRIVE_CFG: nxt_rdata = widen(drive_ff);
            chan_ctrl_pkg::ADDR_OUT_LEVELS: nxt_rdata = widen(out_lvl_ff);
            // Digital inputs and outputs both show pad level
            chan_ctrl_pkg::ADDR_IN_LEVELS: nxt_rdata = widen(lvl_sync_ff & pin_cfg_ff); // R4 R12
            chan_ctrl_pkg::ADDR_GEN_CTRL: nxt_rdata = {31'd0, sw_rst_ff};
            chan_ctrl_pkg::ADDR_STATUS: nxt_rdata = {30'd0, st_ff != ST_IDLE, ready_ff};
            chan_ctrl_pkg::ADDR_RESULT: nxt_rdata = {20'd0, result_ff}; // R10
            default: nxt_rdata = chan_ctrl_pkg::WORD_ZERO;
         endcase
      end
   end

   // Power-up wait: ready after PU_CYC cycles
   always_comb begin
      nxt_pu_cnt = pu_cnt_ff;
      nxt_ready = ready_ff;
      if (!ready_ff) begin
         if (pu_cnt_ff >= 23'(PU_CYC - 1)) begin
            nxt_ready = 1'b1; // R8
         end else begin
            nxt_pu_cnt = pu_cnt_ff + 23'd1;
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         pin_cfg_ff <= chan_ctrl_pkg::RST_CFG; // R1
         dir_cfg_ff <= chan_ctrl_pkg::RST_CFG;
         drive_ff <= chan_ctrl_pkg::RST_CFG;
         out_lvl_ff <= chan_ctrl_pkg::RST_CFG;
         sw_rst_ff <= 1'b0;
         rst_cnt_ff <= '0;
         pu_cnt_ff <= '0;
         ready_ff <= 1'b0;
         ph_wr_ff <= 1'b0;
         ph_rd_ff <= 1'b0;
         ph_addr_ff <= '0;
         rdata_ff <= '0;
         conv_chan_ff <= '0;
         lvl_meta_ff <= '0;
         lvl_sync_ff <= '0;
      end else begin
         pin_cfg_ff <= nxt_pin_cfg;
         dir_cfg_ff <= nxt_dir_cfg;
         drive_ff <= nxt_drive;
         out_lvl_ff <= nxt_out_lvl;
         sw_rst_ff <= nxt_sw_rst;
         rst_cnt_ff <= nxt_rst_cnt;
         pu_cnt_ff <= nxt_pu_cnt;
         ready_ff <= nxt_ready;
         ph_wr_ff <= nxt_ph_wr;
         ph_rd_ff <= nxt_ph_rd;
         ph_addr_ff <= nxt_ph_addr;
         rdata_ff <= nxt_rdata;
         conv_chan_ff <= nxt_conv_chan;
         lvl_meta_ff <= pad_level;
         lvl_sync_ff <= lvl_meta_ff;
      end
   end

   assign hrdata = rdata_ff;
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;

   //--------------------------------------------------------------
   // Conversion: acquisition then successive approximation
   //--------------------------------------------------------------
   always_comb begin
      nxt_st = st_ff;
      nxt_cyc = cyc_ff;
      nxt_bit = bit_ff;
      nxt_trial = trial_ff;
      nxt_result = result_ff;
      nxt_sw = sw_ff;
      case (st_ff)
         ST_IDLE: begin
            if (start_req && !pin_cfg_ff[nxt_conv_chan]) begin
               nxt_st = ST_ACQ;
               nxt_cyc = '0;
               nxt_sw = 1'b1; // R9
            end
         end
         ST_ACQ: begin
            if (cyc_ff >= 5'(chan_ctrl_pkg::ACQ_CYCLES - 1)) begin
               nxt_st = ST_CONV;
               nxt_sw = 1'b0; // R9
               nxt_bit = 4'(RB - 1);
               nxt_trial = {1'b1, {(RB - 1){1'b0}}};
               nxt_cyc = '0;
            end else begin
               nxt_cyc = cyc_ff + 5'd1;
            end
         end
         ST_CONV: begin
            // Straight binary: keep bit while input above trial code
            if (!cmp_out) begin
               nxt_trial[bit_ff] = 1'b0; // R10
            end
            if (bit_ff == 4'd0) begin
               nxt_result = cmp_out ? trial_ff : (trial_ff & ~(12'd1 << bit_ff));
               nxt_st = ST_IDLE;
            end else begin
               nxt_trial[bit_ff - 4'd1] = 1'b1;
               nxt_bit = bit_ff - 4'd1;
            end
         end
         default: nxt_st = ST_IDLE;
      endcase
      if (sw_rst_ff) begin
         nxt_st = ST_IDLE;
         nxt_sw = 1'b0;
      end
      nxt_chan_sel = nxt_sw ? (8'd1 << nxt_conv_chan) : 8'd0; // R9
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         st_ff <= ST_IDLE;
         cyc_ff <= '0;
         bit_ff <= '0;
         trial_ff <= '0;
         result_ff <= '0;
         sw_ff <= 1'b0;
         chan_sel_ff <= '0;
      end else begin
         st_ff <= nxt_st;
         cyc_ff <= nxt_cyc;
         bit_ff <= nxt_bit;
         trial_ff <= nxt_trial;
         result_ff <= nxt_result;
         sw_ff <= nxt_sw;
         chan_sel_ff <= nxt_chan_sel;
      end
   end

   assign sampling_switch = sw_ff;
   assign dac_code = trial_ff;
   assign chan_select = chan_sel_ff;

   //--------------------------------------------------------------
   // Pin domain
   //--------------------------------------------------------------
   pin_link #(.N(N)) u_pins (
      .clk_link(clk_link),
      .rst_link_n(rst_link_n),
      .pin_cfg(pin_cfg_ff),
      .dir_cfg(dir_cfg_ff),
      .output_drive_select(drive_ff),
      .digital_output_levels(out_lvl_ff),
      .pad_in(pad_in),
      .pad_out(pad_out),
      .pad_oe(pad_oe),
      .pad_level(pad_level)
   );

   //--------------------------------------------------------------
   // Checks
   //--------------------------------------------------------------
   property p_rst_defaults;
      @(posedge clk_sys) $rose(rst_n) |-> (pin_cfg_ff == '0 && dir_cfg_ff == '0);
   endproperty
   a_rst_defaults: assert property (p_rst_defaults) else $error("Config not analog after reset"); // R1

   property p_pin_write;
      @(posedge clk_sys) disable iff (!rst_n)
      (ph_wr_ff && ph_addr_ff == chan_ctrl_pkg::ADDR_PIN_CFG && !sw_rst_ff)
      |=> pin_cfg_ff == $past(hwdata[7:0]);
   endproperty
   a_pin_write: assert property (p_pin_write) else $error("Pin config write lost"); // R2

   property p_dir_write;
      @(posedge clk_sys) disable iff (!rst_n)
      (ph_wr_ff && ph_addr_ff == chan_ctrl_pkg::ADDR_DIR_CFG && !sw_rst_ff)
      |=> dir_cfg_ff == $past(hwdata[7:0]);
   endproperty
   a_dir_write: assert property (p_dir_write) else $error("Direction write lost"); // R3

   property p_out_write;
      @(posedge clk_sys) disable iff (!rst_n)
      (ph_wr_ff && ph_addr_ff == chan_ctrl_pkg::ADDR_OUT_LEVELS && !sw_rst_ff)
      |=> out_lvl_ff == $past(hwdata[7:0]);
   endproperty
   a_out_write: assert property (p_out_write) else $error("Output level write lost"); // R5

   property p_in_read;
      @(posedge clk_sys) disable iff (!rst_n)
      (ph_rd_ff && ph_addr_ff == chan_ctrl_pkg::ADDR_IN_LEVELS)
      |-> hrdata[7:0] == ($past(lvl_sync_ff) & $past(pin_cfg_ff));
   endproperty
   a_in_read: assert property (p_in_read) else $error("Input levels read wrong"); // R4

   property p_sw_rst_clears;
      @(posedge clk_sys) disable iff (!rst_n)
      $rose(sw_rst_ff) |-> sw_rst_ff throughout ##1 (pin_cfg_ff == '0)[*2];
   endproperty
   a_sw_rst_clears: assert property (p_sw_rst_clears) else $error("Soft reset did not clear"); // R7

   property p_rst_bound;
      @(posedge clk_sys) disable iff (!rst_n)
      sw_rst_ff |-> rst_cnt_ff < 23'(RST_CYC);
   endproperty
   a_rst_bound: assert property (p_rst_bound) else $error("Soft reset too long"); // R7

   property p_switch_conv;
      @(posedge clk_sys) disable iff (!rst_n)
      (st_ff == ST_CONV) |-> !sampling_switch;
   endproperty
   a_switch_conv: assert property (p_switch_conv) else $error("Switch closed in conversion"); // R9

   property p_acq_len;
      @(posedge clk_sys) disable iff (!rst_n || sw_rst_ff)
      $rose(sampling_switch) |-> sampling_switch[*8] ##1 !sampling_switch;
   endproperty
   a_acq_len: assert property (p_acq_len) else $error("Acquisition length wrong"); // R9

   c_write_pin: cover property (@(posedge clk_sys)
      ph_wr_ff && ph_addr_ff == chan_ctrl_pkg::ADDR_PIN_CFG);
   c_sw_reset: cover property (@(posedge clk_sys) $fell(sw_rst_ff));
   c_conv_done: cover property (@(posedge clk_sys) st_ff == ST_CONV ##1 st_ff == ST_IDLE);
endmodule // chan_ctrl

// ---- logic/pin_link.sv ----
// Pin side of the channel controller, running on the link clock
// Assumes configuration arrives already stable, crossed by two flip-flops here
`timescale 1ns/1ps
module pin_link #(
   parameter int unsigned N = 8
) (
   // Link clock and reset
   input wire logic clk_link,
   input wire logic rst_link_n,
   // Configuration from system domain
   input wire logic [N-1:0] pin_cfg,
   input wire logic [N-1:0] dir_cfg,
   input wire logic [N-1:0] output_drive_select,
   input wire logic [N-1:0] digital_output_levels,
   // Pads
   input wire logic [N-1:0] pad_in,
   output logic [N-1:0] pad_out,
   output logic [N-1:0] pad_oe,
   // Sampled pad levels back to system domain (unsynchronised)
   output logic [N-1:0] pad_level
);
   logic [N-1:0] s1_ff, s2_ff, p1_ff, p2_ff, d1_ff, d2_ff, v1_ff, v2_ff;
   logic [N-1:0] in1_ff, in2_ff;
   logic [N-1:0] out_ff, oe_ff, nxt_out, nxt_oe;

   always_comb begin
      for (int i = 0; i < N; i++) begin
         // Digital output only when gpio and direction out
         if (p2_ff[i] && s2_ff[i]) begin
            // Open-drain drives low only; push-pull drives both
            nxt_out[i] = v2_ff[i];
            nxt_oe[i] = d2_ff[i] | ~v2_ff[i]; // R6 R11
         end else begin
            nxt_out[i] = 1'b0;
            nxt_oe[i] = 1'b0; // R1 R3
         end
      end
   end

   always_ff @(posedge clk_link) begin
      if (!rst_link_n) begin
         {s1_ff, s2_ff, p1_ff, p2_ff} <= '0;
         {d1_ff, d2_ff, v1_ff, v2_ff} <= '0;
         {in1_ff, in2_ff, out_ff, oe_ff} <= '0;
      end else begin
         p1_ff <= pin_cfg;
         p2_ff <= p1_ff;
         s1_ff <= dir_cfg;
         s2_ff <= s1_ff;
         d1_ff <= output_drive_select;
         d2_ff <= d1_ff;
         v1_ff <= digital_output_levels;
         v2_ff <= v1_ff;
         in1_ff <= pad_in;
         in2_ff <= in1_ff;
         out_ff <= nxt_out;
         oe_ff <= nxt_oe;
      end
   end

   assign pad_out = out_ff;
   assign pad_oe = oe_ff;
   assign pad_level = in2_ff;
endmodule // pin_link

// ---- test/pad_partner.sv ----
// Far side model: channel pads with pull levels, sampled analog inputs, comparator
// Assumes pad_oe high while the block drives a pad
`timescale 1ns/1ps
module pad_partner (
   // Clock
   input wire logic clk_sys,
   // Pads
   input wire logic [7:0] pad_out,
   input wire logic [7:0] pad_oe,
   input wire logic [7:0] pull_lvl,
   output logic [7:0] pad_in,
   // Analog front end
   input wire logic [95:0] ain_codes,
   input wire logic sampling_switch,
   input wire logic [7:0] chan_select,
   input wire logic [11:0] dac_code,
   output logic cmp_out
);
   logic [11:0] held_ff;
   // ------
   // Pad wires
   // ------
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         pad_in[i] = pad_oe[i] ? pad_out[i] : pull_lvl[i];
      end
   end
   // ------
   // Sample capacitor, tracks only while the switch is closed
   // ------
   always_ff @(posedge clk_sys) begin
      for (int i = 0; i < 8; i++) begin
         if (sampling_switch && chan_select[i]) begin
            held_ff <= ain_codes[i*12 +: 12];
         end
      end
   end
   assign cmp_out = (held_ff >= dac_code);
endmodule // pad_partner

// ---- test/test_adc_channel_mux_gpio_config.sv ----
// Testbench for chan_ctrl: AHB-Lite register access, pads, soft reset, conversions
// Assumes pad_partner on the pad and analog side, short reset and power-up counts
`timescale 1ns/1ps
module test_adc_channel_mux_gpio_config;
   localparam int unsigned RST_SIM = 20;
   localparam int unsigned PU_SIM = 20;
   localparam logic [7:0] OUTV [2] = '{8'ha5, 8'h5a};
   localparam logic [7:0] OEV [2] = '{8'h70, 8'hb0};
   localparam logic [7:0] DRV [2] = '{8'h20, 8'h10};
   localparam logic [7:0] INV [2] = '{8'h2c, 8'h1c};
   localparam logic [2:0] CH [3] = '{3'h2, 3'h6, 3'h0};
   localparam logic [11:0] CODE [3] = '{12'h800, 12'hfff, 12'h001};
   logic clk_sys, rst_n, clk_link, rst_link_n, hsel, hwrite, hready, hreadyout, hresp;
   logic sampling_switch, cmp_out;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [7:0] pad_in, pad_out, pad_oe, chan_select, pull_lvl;
   logic [11:0] dac_code;
   logic [95:0] ain_codes;
   int mismatches, check_count, n;
   assign hready = hreadyout;
   chan_ctrl #(.RST_CYC(RST_SIM), .PU_CYC(PU_SIM)) uut (.clk_sys(clk_sys), .rst_n(rst_n),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
      .hresp(hresp), .clk_link(clk_link), .rst_link_n(rst_link_n), .pad_in(pad_in),
      .pad_out(pad_out), .pad_oe(pad_oe), .cmp_out(cmp_out),
      .sampling_switch(sampling_switch), .chan_select(chan_select), .dac_code(dac_code));
   pad_partner far_end (.clk_sys(clk_sys), .pad_out(pad_out), .pad_oe(pad_oe),
      .pull_lvl(pull_lvl), .pad_in(pad_in), .ain_codes(ain_codes),
      .sampling_switch(sampling_switch), .chan_select(chan_select), .dac_code(dac_code),
      .cmp_out(cmp_out));
   initial begin
      clk_sys = 1'b0;
      forever #25 clk_sys = ~clk_sys;
   end
   initial begin
      clk_link = 1'b0;
      #13;
      forever #80 clk_link = ~clk_link;
   end
   // ------
   // Report and compare
   // ------
   task automatic complete_run();
      $display("Comparisons %0d, mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         mismatches++;
         $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic give_up();
      mismatches++;
      $display("Wait limit reached at %0t", $time);
      complete_run();
   endtask
   // ------
   // AHB-Lite master
   // ------
   task automatic wait_ready();
      int k;
      k = 0;
      do begin
         @(posedge clk_sys);
         k++;
      end while (hready !== 1'b1 && k < 50);
      if (hready !== 1'b1) give_up();
   endtask
   task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      hsel <= 1'b1;
      haddr <= {24'h00_0000, a};
      htrans <= chan_ctrl_pkg::HTRANS_NONSEQ;
      hwrite <= wr;
      hsize <= 3'h2;
      wait_ready();
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= wd;
      wait_ready();
      rd = hrdata;
      check({31'h0000_0000, hresp}, chan_ctrl_pkg::WORD_ZERO);
   endtask
   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
      ahb(1'b1, a, d);
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      ahb(1'b0, a, chan_ctrl_pkg::WORD_ZERO);
      check(rd, exp);
   endtask
   task automatic poll(input logic [7:0] a, input int b, input logic lvl, input int lim);
      int k;
      k = 0;
      do begin
         ahb(1'b0, a, chan_ctrl_pkg::WORD_ZERO);
         k++;
      end while (rd[b] !== lvl && k < lim);
      if (rd[b] !== lvl) give_up();
   endtask
   // ------
   // Main sequence
   // ------
   initial begin
      rst_n = 1'b0;
      rst_link_n = 1'b0;
      hsel = 1'b0;
      haddr = chan_ctrl_pkg::WORD_ZERO;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = chan_ctrl_pkg::WORD_ZERO;
      pull_lvl = 8'hff;
      ain_codes = {12'h555, 12'hfff, 12'h555, 12'h555, 12'h555, 12'h800, 12'h555, 12'h001};
      mismatches = 0;
      check_count = 0;
      repeat (10) @(posedge clk_sys);
      rst_n <= 1'b1;
      rst_link_n <= 1'b1;
      @(posedge clk_sys);
      poll(chan_ctrl_pkg::ADDR_STATUS, chan_ctrl_pkg::BIT_READY, 1'b1, PU_SIM / 2 + 3);
      rd_chk(chan_ctrl_pkg::ADDR_PIN_CFG, chan_ctrl_pkg::WORD_ZERO);
      rd_chk(chan_ctrl_pkg::ADDR_DIR_CFG, chan_ctrl_pkg::WORD_ZERO);
      rd_chk(chan_ctrl_pkg::ADDR_DRIVE_CFG, chan_ctrl_pkg::WORD_ZERO);
      check({24'h00_0000, pad_oe}, chan_ctrl_pkg::WORD_ZERO);
      // Unmapped place reads zero and ignores writes
      wr_reg(8'h24, 32'hffff_ffff);
      rd_chk(8'h24, chan_ctrl_pkg::WORD_ZERO);
      wr_reg(chan_ctrl_pkg::ADDR_PIN_CFG, 32'h0000_00ff);
      wr_reg(chan_ctrl_pkg::ADDR_DIR_CFG, 32'h0000_12f0);
      rd_chk(chan_ctrl_pkg::ADDR_DIR_CFG, 32'h0000_00f0);
      wr_reg(chan_ctrl_pkg::ADDR_DRIVE_CFG, 32'h0000_0030);
      rd_chk(chan_ctrl_pkg::ADDR_DRIVE_CFG, 32'h0000_0030);
      // Pulldown fault on channels 0, 1, 6 and 7
      pull_lvl <= 8'h3c;
      for (int j = 0; j < 2; j++) begin
         wr_reg(chan_ctrl_pkg::ADDR_OUT_LEVELS, {24'h00_0000, OUTV[j]});
         repeat (30) @(posedge clk_sys);
         check({24'h00_0000, pad_oe}, {24'h00_0000, OEV[j]});
         check({24'h00_0000, pad_out & pad_oe}, {24'h00_0000, DRV[j]});
         rd_chk(chan_ctrl_pkg::ADDR_IN_LEVELS, {24'h00_0000, INV[j]});
      end
      wr_reg(chan_ctrl_pkg::ADDR_PIN_CFG, 32'h0000_000f);
      repeat (30) @(posedge clk_sys);
      check({24'h00_0000, pad_oe}, chan_ctrl_pkg::WORD_ZERO);
      rd_chk(chan_ctrl_pkg::ADDR_IN_LEVELS, 32'h0000_000c);
      // Soft reset clears itself and restores analog mode
      wr_reg(chan_ctrl_pkg::ADDR_GEN_CTRL, 32'h0000_0001);
      rd_chk(chan_ctrl_pkg::ADDR_GEN_CTRL, 32'h0000_0001);
      poll(chan_ctrl_pkg::ADDR_GEN_CTRL, chan_ctrl_pkg::BIT_SW_RESET, 1'b0, RST_SIM / 2 + 2);
      rd_chk(chan_ctrl_pkg::ADDR_PIN_CFG, chan_ctrl_pkg::WORD_ZERO);
      repeat (30) @(posedge clk_sys);
      check({24'h00_0000, pad_oe}, chan_ctrl_pkg::WORD_ZERO);
      // Conversions on analog channels
      for (int j = 0; j < 3; j++) begin
         wr_reg(chan_ctrl_pkg::ADDR_CONV_CTRL, {25'h000_0000, CH[j], 4'h1});
         n = 0;
         while (sampling_switch !== 1'b1 && n < 10) begin
            @(negedge clk_sys);
            n++;
         end
         check({24'h00_0000, chan_select}, {24'h00_0000, 8'h01 << CH[j]});
         n = 0;
         while (sampling_switch === 1'b1 && n < 20) begin
            @(negedge clk_sys);
            n++;
         end
         check(n, chan_ctrl_pkg::ACQ_CYCLES);
         check({24'h00_0000, chan_select}, chan_ctrl_pkg::WORD_ZERO);
         @(posedge clk_sys);
         poll(chan_ctrl_pkg::ADDR_STATUS, chan_ctrl_pkg::BIT_BUSY, 1'b0, 20);
         rd_chk(chan_ctrl_pkg::ADDR_RESULT, {20'h0_0000, CODE[j]});
      end
      complete_run();
   end
endmodule // test_adc_channel_mux_gpio_config
